// ===== bench/cpu_bus_model.sv
`timescale 1ns/1ns
module cpu_bus_model (
	input  wire logic       clk_sys,                // System clock
	input  wire logic       ack,                    // Access acknowledge
	input  wire logic       read_data_latch_strobe, // Read word latch
	output logic            dram_sel,               // Region select
	output logic            rd_req,                 // Read strobe
	output logic            wr_req,                 // Write strobe
	output logic            burst,                  // Quad read mark
	output logic            near_write_indication,  // Same page write
	output logic      [1:0] bank_addr,              // Bank address bits
	output logic      [3:0] byte_en                 // Write byte lanes
);
	int rdl_at[$];

	initial begin
		{dram_sel, rd_req, wr_req, burst, near_write_indication} = 5'h00;
		bank_addr = 2'h0;
		byte_en   = 4'h0;
	end

	// ------------------------------------------------------------
	// One access, held until acknowledge, then released
	// ------------------------------------------------------------
	task automatic access(input logic r, w, b, nw, input logic [1:0] bk, output int lat);
		int n;
		n = 0;
		lat = 0;
		rdl_at.delete();
		@(posedge clk_sys);
		dram_sel  <= 1'b1;
		rd_req    <= r;
		wr_req    <= w;
		burst     <= b & r;
		near_write_indication <= nw;
		bank_addr <= bk;
		byte_en   <= w ? 4'h5 : 4'hF;
		while (lat == 0 && n < 40) begin
			@(posedge clk_sys);
			n++;
			if (read_data_latch_strobe === 1'b1) rdl_at.push_back(n);
			if (ack === 1'b1) lat = n;
		end
		// Released address lines must not keep their old value
		{dram_sel, rd_req, wr_req, burst, near_write_indication} <= 5'h00;
		bank_addr <= ~bk;
		byte_en   <= ~byte_en;
		repeat (6) begin
			@(posedge clk_sys);
			n++;
			if (read_data_latch_strobe === 1'b1) rdl_at.push_back(n);
		end
	endtask : access
endmodule : cpu_bus_model

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
	import dram_ctl_pkg::*;
	logic       clk_sys = 1'b0, reset_n = 1'b0, ref_req = 1'b0;
	logic       dram_sel, rd_req, wr_req, burst, nwi, rdl, ack, ref_ack;
	logic [1:0] bank_addr, word_idx;
	logic [3:0] byte_en, ras_n, cas_n, we_n, cas_q = 4'hF;
	logic [7:0] widx_seq = 8'h00, wr_seen = 8'h00;
	int         failures = 0, tests_run = 0, cbr_cnt = 0, cas_fall = 0, lat, c0, f0;

	always #2 clk_sys = ~clk_sys;

	dram_ctl dut (.clk_sys(clk_sys), .reset_n(reset_n), .dram_sel(dram_sel), .rd_req(rd_req),
		.wr_req(wr_req), .burst(burst), .near_write_indication(nwi), .bank_addr(bank_addr),
		.byte_en(byte_en), .ref_req(ref_req), .ref_ack(ref_ack), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .read_data_latch_strobe(rdl), .ack(ack), .word_idx(word_idx));

	cpu_bus_model cpu (.clk_sys(clk_sys), .ack(ack), .read_data_latch_strobe(rdl), .dram_sel(dram_sel),
		.rd_req(rd_req), .wr_req(wr_req), .burst(burst), .near_write_indication(nwi),
		.bank_addr(bank_addr), .byte_en(byte_en));

	// Column-before-row cycles, column strobe falls, word index per latch, write strobes
	always @(posedge clk_sys) begin
		cas_q <= cas_n;
		if (rdl === 1'b1) widx_seq <= {widx_seq[5:0], word_idx};
		if (we_n !== 4'hF) wr_seen <= {we_n, cas_n};
		if (cas_n === 4'h0 && ras_n === 4'hF) cbr_cnt++;
		if (cas_q === 4'hF && cas_n !== 4'hF) cas_fall++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic t_reset();
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk_sys);
		check(cbr_cnt != 0, 1);
		check({ras_n, cas_n, we_n, ack, rdl}, 14'h3FFC);
		// no access before eight refresh periods
		repeat (8 * REF_PERIOD_CYC) @(posedge clk_sys);
		$display("test reset done");
	endtask : t_reset

	task automatic t_sread();
		cpu.access(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, lat);
		check(lat, 6);
		check(cpu.rdl_at.size(), 1);
		check(cpu.rdl_at[0], 6);
		$display("test single read done");
	endtask : t_sread

	task automatic t_qread();
		f0 = cas_fall;
		cpu.access(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, lat);
		check(lat, 9);
		check(cpu.rdl_at.size(), 4);
		for (int i = 1; i < 4; i++)
			check(cpu.rdl_at[i] - cpu.rdl_at[i-1], 2);
		check(lat > cpu.rdl_at[1] && lat < cpu.rdl_at[2], 1);
		check(cas_fall - f0, 4);
		check(widx_seq, 8'h1B);
		$display("test quad read done");
	endtask : t_qread

	task automatic t_writes();
		cpu.access(1'b0, 1'b1, 1'b0, 1'b0, 2'h2, lat);
		check(lat, 5);
		check(wr_seen, 8'hBA);
		check(ras_n, 4'hB);
		cpu.access(1'b0, 1'b1, 1'b0, 1'b1, 2'h2, lat);
		check(lat, 4);
		check(ras_n, 4'hB);
		cpu.access(1'b1, 1'b0, 1'b0, 1'b0, 2'h2, lat);
		check(lat, 9);
		check(ras_n, 4'hF);
		$display("test writes done");
	endtask : t_writes

	task automatic t_ref_mid();
		c0 = cbr_cnt;
		fork
			cpu.access(1'b1, 1'b0, 1'b0, 1'b0, 2'h3, lat);
			begin
				repeat (2) @(posedge clk_sys);
				ref_req <= 1'b1;
				@(posedge clk_sys);
				ref_req <= 1'b0;
				@(posedge clk_sys);
				check(ref_ack, 1'b1);
			end
		join
		check(lat, 6);
		check(cbr_cnt != c0, 1);
		@(posedge clk_sys);
		check(ref_ack, 1'b0);
		$display("test refresh mid access done");
	endtask : t_ref_mid

	task automatic t_ref_first();
		c0 = cbr_cnt;
		@(posedge clk_sys);
		ref_req <= 1'b1;
		fork
			cpu.access(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, lat);
			begin
				@(posedge clk_sys);
				ref_req <= 1'b0;
			end
		join
		check(lat > 6, 1);
		check(cbr_cnt != c0, 1);
		$display("test refresh first done");
	endtask : t_ref_first

	initial begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		end_sim();
	end

	initial begin
		t_reset();
		t_sread();
		t_qread();
		t_writes();
		t_ref_mid();
		t_ref_first();
		end_sim();
	end
endmodule : tb

// ===== src/cycle_counter.sv
`timescale 1ns/1ns
module cycle_counter
	import dram_ctl_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         clk_sys,  // System clock
	input  wire logic         reset_n,  // Async reset, active low
	input  wire logic         run,      // Advance when high, else hold at zero
	output logic      [W-1:0] count     // Cycles since start of step
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	always_comb begin
		count_nxt = run ? W'(count_r + 1'b1) : '0;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count = count_r;
endmodule : cycle_counter

// ===== src/dram_ctl.sv
// Operation
// R1 - Strobe and reply timing comes from a four-bit counter on the system clock.
// R2 - Nine major states; next state follows transfer type and prior state.
// R3 - Reset returns to initial state, does one refresh, then idles.
// R4 - Access starts on region select with read or write strobe.
// R5 - Quad read, single read, single write and page write are supported.
// R6 - After any write, idle with the bank row strobe still low.
// R7 - Refresh starts on each timer request pulse, nominally every 9.6 us.
// R8 - Accepted refresh raises acknowledge, holding timer until refresh done.
// R9 - Refresh beats processor requests; running cycles finish first.
// R10 - Refresh only column-before-row; no other refresh method.
// R11 - Idle deasserts all controls, halts counter, keeps watching requests.
// R12 - Single read gives latch strobe and acknowledge at cycle four.
// R13 - Quad read is read plus burst; low word address walks four words.
// R14 - Quad read: first word single timing, then one word per two clocks.
// R15 - Quad read acknowledge falls between second and third word.
// R16 - Quad read holds row strobe and toggles column strobes four times.
// R17 - Single write writes enabled lanes; acknowledge at cycle three.
// R18 - After a write, assume same page and keep row strobe low.
// R19 - Row-held idle: near write enters page write, else leave.
// R20 - Page write skips row activation; acknowledge at cycle two.
// R21 - Non page-write access after row-held idle precharges rows first.
// R22 - Quad read acknowledge at cycle seven of the access.
// R23 - Boot code must wait eight refresh periods before any DRAM access.
// R24 - Two address bits pick one of four banks; lanes span banks.
// R25 - Refresh arriving mid-access is latched and served right after.
`timescale 1ns/1ns
module dram_ctl
	import dram_ctl_pkg::*;
#(
	parameter int NBANK = BANKS,
	parameter int NLANE = LANES
) (
	input  wire logic             clk_sys,                // System clock, 250 MHz
	input  wire logic             reset_n,                // Async reset, active low
	input  wire logic             dram_sel,               // DRAM region select
	input  wire logic             rd_req,                 // Processor read strobe
	input  wire logic             wr_req,                 // Processor write strobe
	input  wire logic             burst,                  // Quad-word read indication
	input  wire logic             near_write_indication,  // Write hits open page
	input  wire logic [1:0]       bank_addr,              // Address bits 21:20
	input  wire logic [NLANE-1:0] byte_en,                // Byte lanes for writes
	input  wire logic             ref_req,                // Refresh timer pulse
	output logic                  ref_ack,                // Refresh acknowledge
	output logic      [NBANK-1:0] ras_n,                  // Row strobe per bank
	output logic      [NLANE-1:0] cas_n,                  // Column strobe per lane
	output logic      [NBANK-1:0] we_n,                   // Write enable per bank
	output logic                  read_data_latch_strobe, // Latch read word
	output logic                  ack,                    // Access acknowledge
	output logic      [1:0]       word_idx                // Quad read word being read
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dram_state_t      state_r, state_nxt;
	logic [1:0]       bank_r, bank_nxt;
	logic             ref_pend_r, ref_pend_nxt;
	logic [NBANK-1:0] ras_n_r, ras_n_nxt;
	logic [NLANE-1:0] cas_n_r, cas_n_nxt;
	logic [NBANK-1:0] we_n_r, we_n_nxt;
	logic             rdl_r, rdl_nxt;
	logic             ack_r, ack_nxt;
	logic [1:0]       word_r, word_nxt;
	logic             run;
	logic [3:0]       cnt;
	logic             access;
	logic             qread;

	// R1 counter timing
	cycle_counter #(.W(CNT_W)) u_cnt (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.run     (run),
		.count   (cnt)
	);

	// R4 access start
	assign access = dram_sel && (rd_req || wr_req);
	// R13 burst decode
	assign qread  = rd_req && burst;

	// R11 counter halts in idle states
	assign run = !(state_r == ST_IDLE || state_r == ST_IDLE_RAS) && state_nxt == state_r;

	// ----------------------------------------------------------------
	// Next state and outputs
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		bank_nxt     = bank_r;
		ref_pend_nxt = ref_pend_r;
		ras_n_nxt    = '1;
		cas_n_nxt    = '1;
		we_n_nxt     = '1;
		rdl_nxt      = 1'b0;
		ack_nxt      = 1'b0;
		word_nxt     = word_r;
		// R25 latch refresh; a new pulse wins over the clear
		if (ref_req) begin
			ref_pend_nxt = 1'b1;
		end
		// R2 nine major states
		unique case (state_r)
			ST_RESET: begin
				// R3 one refresh after reset release
				state_nxt = ST_REFRESH;
			end
			ST_IDLE: begin
				// R7 R9 refresh first
				if (ref_pend_r || ref_req) begin
					state_nxt = ST_REFRESH;
				end else if (access) begin
					bank_nxt  = bank_addr;
					word_nxt  = 2'b00;
					// R5 decode access type
					if (qread) begin
						state_nxt = ST_QREAD;
					end else if (rd_req) begin
						state_nxt = ST_SREAD;
					end else begin
						state_nxt = ST_SWRITE;
					end
				end
			end
			ST_REFRESH: begin
				// R10 column strobes before row strobes
				if (cnt >= REF_CAS_CYC && cnt < REF_END_CYC) begin
					cas_n_nxt = '0;
				end
				if (cnt >= REF_RAS_CYC && cnt < REF_END_CYC) begin
					ras_n_nxt = '0;
				end
				if (cnt == REF_END_CYC) begin
					// R8 timer released once refresh is done
					ref_pend_nxt = ref_req;
					state_nxt    = ST_IDLE;
				end
			end
			ST_SREAD: begin
				ras_n_nxt[bank_r] = 1'b0;
				if (cnt >= CNT_ONE && cnt < SR_ACK_CYC) begin
					cas_n_nxt = '0;
				end
				// R12 latch and ack at cycle four
				if (cnt == SR_ACK_CYC - CNT_ONE) begin
					rdl_nxt = 1'b1;
					ack_nxt = 1'b1;
				end
				if (cnt == SR_ACK_CYC) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_QREAD: begin
				// R16 row held, columns toggled per word
				ras_n_nxt[bank_r] = 1'b0;
				if (cnt >= CNT_ONE && cnt < SR_ACK_CYC) begin
					cas_n_nxt = '0;
				// Column low in the cycle of each latch pulse, never after it
				end else if (cnt > SR_ACK_CYC && cnt[0] != SR_ACK_CYC[0] && cnt < QR_LAST_CYC) begin
					cas_n_nxt = '0;
				end
				// R14 first word at four, then every two clocks
				if (cnt >= SR_ACK_CYC - CNT_ONE && cnt < QR_LAST_CYC &&
				    cnt[0] == SR_ACK_CYC[0] - 1'b1) begin
					rdl_nxt = 1'b1;
				end
				if (rdl_r) begin
					word_nxt = 2'(word_r + 1'b1);
				end
				// R15 R22 ack at cycle seven, between words two and three
				if (cnt == QR_ACK_CYC - CNT_ONE) begin
					ack_nxt = 1'b1;
				end
				if (cnt == QR_LAST_CYC) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_SWRITE: begin
				ras_n_nxt[bank_r] = 1'b0;
				// R17 enabled lanes only, ack at three
				if (cnt >= CNT_ONE) begin
					cas_n_nxt        = ~byte_en;
					we_n_nxt[bank_r] = 1'b0;
				end
				if (cnt == SW_ACK_CYC - CNT_ONE) begin
					ack_nxt = 1'b1;
				end
				if (cnt == SW_ACK_CYC) begin
					// R6 R18 keep row open after write
					cas_n_nxt = '1;
					we_n_nxt  = '1;
					state_nxt = ST_IDLE_RAS;
				end
			end
			ST_IDLE_RAS: begin
				// R6 row stays low while idling
				ras_n_nxt[bank_r] = 1'b0;
				// R19 near write reuses page; else precharge
				// Rows go high on the way into precharge, not one cycle late
				if (ref_pend_r || ref_req) begin
					ras_n_nxt = '1;
					state_nxt = ST_PRECHARGE;
				end else if (access && wr_req && near_write_indication && bank_addr == bank_r) begin
					state_nxt = ST_PWRITE;
				end else if (access) begin
					ras_n_nxt = '1;
					state_nxt = ST_PRECHARGE;
				end
			end
			ST_PWRITE: begin
				// R20 no row activation, ack at two
				ras_n_nxt[bank_r] = 1'b0;
				cas_n_nxt         = ~byte_en;
				we_n_nxt[bank_r]  = 1'b0;
				if (cnt == PW_ACK_CYC - CNT_ONE) begin
					ack_nxt = 1'b1;
				end
				if (cnt == PW_ACK_CYC) begin
					cas_n_nxt = '1;
					we_n_nxt  = '1;
					state_nxt = ST_IDLE_RAS;
				end
			end
			ST_PRECHARGE: begin
				// R21 rows high before serving access
				if (cnt == PRE_CYC) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= ST_RESET;
			bank_r     <= 2'h0;
			ref_pend_r <= 1'b0;
			ras_n_r    <= '1;
			cas_n_r    <= '1;
			we_n_r     <= '1;
			rdl_r      <= 1'b0;
			ack_r      <= 1'b0;
			word_r     <= 2'h0;
		end else begin
			state_r    <= state_nxt;
			bank_r     <= bank_nxt;
			ref_pend_r <= ref_pend_nxt;
			ras_n_r    <= ras_n_nxt;
			cas_n_r    <= cas_n_nxt;
			we_n_r     <= we_n_nxt;
			rdl_r      <= rdl_nxt;
			ack_r      <= ack_nxt;
			word_r     <= word_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// R8 acknowledge held while refresh pending; locks the timer
	assign ref_ack                = ref_pend_r;
	// R24 one row strobe and write enable per bank, lanes shared
	assign ras_n                  = ras_n_r;
	assign cas_n                  = cas_n_r;
	assign we_n                   = we_n_r;
	assign read_data_latch_strobe = rdl_r;
	assign ack                    = ack_r;
	assign word_idx               = word_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_SREAD_ACK: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
		(state_r == ST_IDLE && state_nxt == ST_SREAD) |-> ##5 (ack && read_data_latch_strobe))
		else $error("single read ack not at cycle four");
	AST_QREAD_ACK: assert property (@(posedge clk_sys) disable iff (!reset_n) // R22
		(state_r == ST_IDLE && state_nxt == ST_QREAD) |-> ##8 ack)
		else $error("quad read ack not at cycle seven");
	AST_SWRITE_ACK: assert property (@(posedge clk_sys) disable iff (!reset_n) // R17
		(state_r == ST_IDLE && state_nxt == ST_SWRITE) |-> ##4 ack)
		else $error("write ack not at cycle three");
	AST_PWRITE_ACK: assert property (@(posedge clk_sys) disable iff (!reset_n) // R20
		(state_r == ST_IDLE_RAS && state_nxt == ST_PWRITE) |-> ##3 ack)
		else $error("page write ack not at cycle two");
	AST_QREAD_WORDS: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
		(state_r == ST_IDLE && state_nxt == ST_QREAD) |->
		##5 read_data_latch_strobe ##2 read_data_latch_strobe ##2 read_data_latch_strobe
		##2 read_data_latch_strobe)
		else $error("quad read words not one per two clocks");
	AST_REF_CBR: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
		$fell(ras_n[0]) && state_r == ST_REFRESH |-> $past(cas_n == '0))
		else $error("refresh row strobe before column strobe");
	AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
		state_r == ST_IDLE && $past(state_r) == ST_IDLE |-> (ras_n == '1 && cas_n == '1 && cnt == CNT_ZERO))
		else $error("idle state drives controls");
	AST_ROW_HELD: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
		state_r == ST_IDLE_RAS && $past(state_r) == ST_IDLE_RAS |-> ras_n[bank_r] == 1'b0)
		else $error("row strobe released in row-held idle");
	AST_REF_PRIO: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
		state_r == ST_IDLE && ref_pend_r |=> state_r == ST_REFRESH)
		else $error("pending refresh not served first");
	AST_PRECHARGE: assert property (@(posedge clk_sys) disable iff (!reset_n) // R21
		state_r == ST_PRECHARGE |-> ras_n == '1)
		else $error("rows not high in precharge");
endmodule : dram_ctl

// ===== src/dram_ctl_pkg.sv
package dram_ctl_pkg;
	// ----------------------------------------------------------------
	// Bank, lane and counter geometry
	// ----------------------------------------------------------------
	localparam int          CNT_W       = 4;
	localparam int          BANKS       = 4;
	localparam int          LANES       = 4;
	localparam int          BANK_SEL_LO = 20;
	localparam int          BANK_SEL_HI = 21;
	localparam int          ADDR_W      = 22;

	// ----------------------------------------------------------------
	// Timing, in cycles from entry into the current controller state
	// ----------------------------------------------------------------
	localparam logic [3:0]  CNT_ZERO     = 4'h0;
	localparam logic [3:0]  CNT_ONE      = 4'h1;
	localparam logic [3:0]  SR_ACK_CYC   = 4'h4;
	localparam logic [3:0]  QR_ACK_CYC   = 4'h7;
	localparam logic [3:0]  QR_LAST_CYC  = 4'hA;
	localparam logic [3:0]  SW_ACK_CYC   = 4'h3;
	localparam logic [3:0]  PW_ACK_CYC   = 4'h2;
	localparam logic [3:0]  PRE_CYC      = 4'h1;
	localparam logic [3:0]  REF_CAS_CYC  = 4'h1;
	localparam logic [3:0]  REF_RAS_CYC  = 4'h2;
	localparam logic [3:0]  REF_END_CYC  = 4'h4;
	localparam logic [3:0]  QR_WORD_GAP  = 4'h2;

	// Refresh interval kept by the outside timer
	localparam real         REF_PERIOD_NS = 9600.0;
	localparam real         CLK_PERIOD_NS = 4.0;
	localparam int          REF_PERIOD_CYC = int'(REF_PERIOD_NS / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET,
		ST_IDLE,
		ST_REFRESH,
		ST_SREAD,
		ST_QREAD,
		ST_SWRITE,
		ST_IDLE_RAS,
		ST_PWRITE,
		ST_PRECHARGE
	} dram_state_t;
endpackage : dram_ctl_pkg
